// ==== src/crt_cmd_pkg.sv ====
// constants and types shared by the command and status interpreter
// Overview of operation
// - each command needs its exact count of parameter bytes; early command flags improper
// - seven commands: reset takes four bytes, load cursor two, others none
// - reset command drops buffer request, disables interrupts, blanks video; retraces keep running
// - first reset byte: spaced rows bit, characters per row minus one
// - second reset byte: vertical retrace rows minus one, rows per frame minus one
// - third reset byte upper nibble: underline line number minus one
// - third reset byte lower nibble: lines per row minus one
// - underline field MSB set blanks top and bottom lines of each row
// - fourth reset byte MSB selects offset line counter mode
// - fourth reset byte bits 5 and 4 select cursor style
// - fourth reset byte low nibble: horizontal retrace is twice field plus two
// - start display enables interrupts, buffer request and video, sets both flags
// - stop display disables video and buffer request; only start display restores them
// - load cursor stores character position then row; flags unchanged
// - enable interrupt sets enable flag; disable interrupt clears it
// - preset counters holds timing at top left until another command
// - status reads 0, enable, request, 0, improper, video, underrun, 0
// - interrupt request sets at last row start if enabled; clears on status read
// - improper flag sets on too long or short parameters; clears on status read
// - reset clears interrupt enable; reset and stop clear video enable
// - underrun sets flag, stops loading, blanks screen until vertical retrace ends
// - select high writes command or reads status; low writes parameter
// - interrupt output drops after a status read
package crt_cmd_pkg;
	localparam logic [7:0] CMD_RESET = 8'h00;
	localparam logic [7:0] CMD_START = 8'h20;
	localparam logic [7:0] CMD_STOP = 8'h40;
	localparam logic [7:0] CMD_CURSOR = 8'h80;
	localparam logic [7:0] CMD_INT_ON = 8'hA0;
	localparam logic [7:0] CMD_INT_OFF = 8'hC0;
	localparam logic [7:0] CMD_PRESET = 8'hE0;
	localparam logic [2:0] RESET_PARAMS = 3'h4;
	localparam logic [2:0] CURSOR_PARAMS = 3'h2;
	localparam int STAT_IE = 6;
	localparam int STAT_IR = 5;
	localparam int STAT_IC = 3;
	localparam int STAT_VE = 2;
	localparam int STAT_BU = 1;
	localparam logic [7:0] SCREEN1_RESET = 8'h4F;
	localparam logic [7:0] SCREEN2_RESET = 8'h18;
	localparam logic [7:0] SCREEN3_RESET = 8'h99;
	localparam logic [7:0] SCREEN4_RESET = 8'h99;
	localparam int PRESET_CYCLES = 2;
	typedef enum logic [2:0]
	{
		OP_NONE = 3'b000,
		OP_RESET = 3'b001,
		OP_CURSOR = 3'b010,
		OP_OTHER = 3'b011
	} op_type;
	function automatic logic [2:0] param_count(input op_type op);
		case (op)
			OP_RESET: param_count = RESET_PARAMS;
			OP_CURSOR: param_count = CURSOR_PARAMS;
			default: param_count = 3'h0;
		endcase
	endfunction : param_count
endpackage : crt_cmd_pkg

// ==== src/crt_param_if.sv ====
// parameter byte strobe from the interpreter to the screen field store
interface crt_param_if;
	logic strobe;
	logic [1:0] index;
	logic [7:0] data;
	logic isReset;
	modport source (output strobe, output index, output data, output isReset);
	modport sink (input strobe, input index, input data, input isReset);
endinterface : crt_param_if

// ==== src/crt_screen_fields.sv ====
// screen composition and cursor registers loaded from parameter bytes
module crt_screen_fields
(
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// parameter bytes
	crt_param_if.sink prm,
	// field values
	output logic [7:0] screen1,
	output logic [7:0] screen2,
	output logic [7:0] screen3,
	output logic [7:0] screen4,
	output logic [7:0] cursorChar,
	output logic [7:0] cursorRow
);
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			screen1 <= crt_cmd_pkg::SCREEN1_RESET;
			screen2 <= crt_cmd_pkg::SCREEN2_RESET;
			screen3 <= crt_cmd_pkg::SCREEN3_RESET;
			screen4 <= crt_cmd_pkg::SCREEN4_RESET;
		end
		else if (prm.strobe && prm.isReset)
		begin
			case (prm.index)
				2'h0: screen1 <= prm.data;
				2'h1: screen2 <= prm.data;
				2'h2: screen3 <= prm.data;
				default: screen4 <= prm.data;
			endcase
		end
	end

	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			cursorChar <= 8'h00;
			cursorRow <= 8'h00;
		end
		else if (prm.strobe && !prm.isReset)
		begin
			if (prm.index == 2'h0)
				cursorChar <= prm.data;
			else
				cursorRow <= prm.data;
		end
	end
endmodule : crt_screen_fields

// ==== src/crt_command_status.sv ====
// command decode, status word and display enables of the crt controller
module crt_command_status
(
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// host bus
	input wire logic hostWrite,
	input wire logic hostRead,
	input wire logic command_param_select,
	input wire logic [7:0] writeData,
	output logic [7:0] readData,
	// raster events
	input wire logic lastRowStart,
	input wire logic vretraceEnd,
	input wire logic underrunEvent,
	// control outputs
	output logic interrupt_request_out,
	output logic buffer_request,
	output logic video_suppress,
	output logic presetCounters,
	// screen fields
	output logic spacedRows,
	output logic [6:0] charsPerRow,
	output logic [1:0] vretraceRows,
	output logic [5:0] rowsPerFrame,
	output logic [3:0] underlineLine,
	output logic [3:0] linesPerRow,
	output logic blankEdgeLines,
	output logic lineCountOffset,
	output logic [1:0] cursorFormat,
	output logic [3:0] hretraceCount,
	output logic [7:0] cursorChar,
	output logic [7:0] cursorRow
);
	crt_param_if prm ();
	crt_cmd_pkg::op_type op;
	logic [2:0] paramIndex;
	logic int_enable_flag;
	logic int_request_flag;
	logic bad_command_flag;
	logic video_enable_flag;
	logic buffer_underrun_flag;
	logic [7:0] screen1;
	logic [7:0] screen2;
	logic [7:0] screen3;
	logic [7:0] screen4;
	logic [7:0] nextCursorChar;
	logic [7:0] nextCursorRow;
	logic cmdWrite;
	logic prmWrite;
	logic statusRead;
	logic shortParams;
	logic longParams;
	crt_cmd_pkg::op_type next_op;

	// select line steers writes and reads
	assign cmdWrite = hostWrite && command_param_select;
	assign prmWrite = hostWrite && !command_param_select;
	assign statusRead = hostRead && command_param_select;
	assign shortParams = cmdWrite && (paramIndex < crt_cmd_pkg::param_count(op));
	assign longParams = prmWrite && (paramIndex >= crt_cmd_pkg::param_count(op));

	always_comb
	begin
		case (writeData)
			crt_cmd_pkg::CMD_RESET: next_op = crt_cmd_pkg::OP_RESET;
			crt_cmd_pkg::CMD_CURSOR: next_op = crt_cmd_pkg::OP_CURSOR;
			default: next_op = crt_cmd_pkg::OP_OTHER;
		endcase
	end

	assign prm.strobe = prmWrite && !longParams;
	assign prm.index = paramIndex[1:0];
	assign prm.data = writeData;
	assign prm.isReset = (op == crt_cmd_pkg::OP_RESET);

	crt_screen_fields fields
	(
		.sys_clk(sys_clk),
		.rst(rst),
		.prm(prm),
		.screen1(screen1),
		.screen2(screen2),
		.screen3(screen3),
		.screen4(screen4),
		.cursorChar(nextCursorChar),
		.cursorRow(nextCursorRow)
	);

	// current command and parameter index
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			op <= crt_cmd_pkg::OP_NONE;
			paramIndex <= 3'h0;
		end
		else if (cmdWrite)
		begin
			op <= next_op;
			paramIndex <= 3'h0;
		end
		else if (prm.strobe)
			paramIndex <= paramIndex + 3'h1;
	end

	// interrupt enable flag
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
			int_enable_flag <= 1'b0;
		else if (cmdWrite)
		begin
			case (writeData)
				crt_cmd_pkg::CMD_RESET: int_enable_flag <= 1'b0;
				crt_cmd_pkg::CMD_START: int_enable_flag <= 1'b1;
				crt_cmd_pkg::CMD_INT_ON: int_enable_flag <= 1'b1;
				crt_cmd_pkg::CMD_INT_OFF: int_enable_flag <= 1'b0;
				default: int_enable_flag <= int_enable_flag;
			endcase
		end
	end

	// video enable flag
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
			video_enable_flag <= 1'b0;
		else if (cmdWrite)
		begin
			case (writeData)
				crt_cmd_pkg::CMD_RESET: video_enable_flag <= 1'b0;
				crt_cmd_pkg::CMD_STOP: video_enable_flag <= 1'b0;
				crt_cmd_pkg::CMD_START: video_enable_flag <= 1'b1;
				default: video_enable_flag <= video_enable_flag;
			endcase
		end
	end

	// interrupt request: a new frame event wins over the clearing read
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
			int_request_flag <= 1'b0;
		else if (lastRowStart && int_enable_flag)
			int_request_flag <= 1'b1;
		else if (statusRead || (cmdWrite && writeData == crt_cmd_pkg::CMD_RESET))
			int_request_flag <= 1'b0;
	end

	// improper command flag, set wins over read clear
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
			bad_command_flag <= 1'b0;
		else if (shortParams || longParams)
			bad_command_flag <= 1'b1;
		else if (statusRead)
			bad_command_flag <= 1'b0;
	end

	// underrun: loading stops and screen blanks until vertical retrace ends
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
			buffer_underrun_flag <= 1'b0;
		else if (underrunEvent && video_enable_flag)
			buffer_underrun_flag <= 1'b1;
		else if (vretraceEnd)
			buffer_underrun_flag <= 1'b0;
	end

	// status word register
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
			readData <= 8'h00;
		else if (statusRead)
		begin
			readData <= 8'h00;
			readData[crt_cmd_pkg::STAT_IE] <= int_enable_flag;
			readData[crt_cmd_pkg::STAT_IR] <= int_request_flag;
			readData[crt_cmd_pkg::STAT_IC] <= bad_command_flag;
			readData[crt_cmd_pkg::STAT_VE] <= video_enable_flag;
			readData[crt_cmd_pkg::STAT_BU] <= buffer_underrun_flag;
		end
	end

	// display control outputs, retrace timing is not touched here
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			interrupt_request_out <= 1'b0;
			buffer_request <= 1'b0;
			video_suppress <= 1'b1;
		end
		else
		begin
			interrupt_request_out <= int_request_flag && !statusRead;
			buffer_request <= video_enable_flag && !buffer_underrun_flag;
			video_suppress <= !video_enable_flag || buffer_underrun_flag;
		end
	end

	// preset counters holds until any other command
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
			presetCounters <= 1'b0;
		else if (cmdWrite)
			presetCounters <= (writeData == crt_cmd_pkg::CMD_PRESET);
	end

	// field outputs registered from the field store
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			spacedRows <= 1'b0;
			charsPerRow <= 7'h00;
			vretraceRows <= 2'h0;
			rowsPerFrame <= 6'h00;
			underlineLine <= 4'h0;
			linesPerRow <= 4'h0;
			blankEdgeLines <= 1'b0;
			lineCountOffset <= 1'b0;
			cursorFormat <= 2'h0;
			hretraceCount <= 4'h0;
			cursorChar <= 8'h00;
			cursorRow <= 8'h00;
		end
		else
		begin
			spacedRows <= screen1[7];
			charsPerRow <= screen1[6:0];
			vretraceRows <= screen2[7:6];
			rowsPerFrame <= screen2[5:0];
			underlineLine <= screen3[7:4];
			linesPerRow <= screen3[3:0];
			blankEdgeLines <= screen3[7];
			lineCountOffset <= screen4[7];
			cursorFormat <= screen4[5:4];
			hretraceCount <= screen4[3:0];
			cursorChar <= nextCursorChar;
			cursorRow <= nextCursorRow;
		end
	end
endmodule : crt_command_status

// ==== verif/crt_cmd_assertions.sv ====
// concurrent checks on the ports of the command and status interpreter
module crt_cmd_checker
(
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// host bus and events
	input wire logic hostWrite,
	input wire logic hostRead,
	input wire logic command_param_select,
	input wire logic [7:0] writeData,
	input wire logic [7:0] readData,
	input wire logic lastRowStart,
	input wire logic underrunEvent,
	// control outputs
	input wire logic interrupt_request_out,
	input wire logic buffer_request,
	input wire logic video_suppress,
	input wire logic presetCounters
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (rst);
	logic cmdW;
	assign cmdW = hostWrite && command_param_select;
	stop_blanks_a: assert property (
		cmdW && writeData == 8'h40 |-> ##2 video_suppress && !buffer_request)
		else $error("stop command left video on");
	reset_quiets_a: assert property (
		cmdW && writeData == 8'h00 && !lastRowStart && !$past(lastRowStart)
		|-> ##2 video_suppress && !buffer_request && !interrupt_request_out)
		else $error("reset command left outputs active");
	preset_set_a: assert property (
		cmdW && writeData == 8'hE0 |-> ##[1:2] presetCounters)
		else $error("preset not raised");
	preset_hold_a: assert property (
		presetCounters && !cmdW && !$past(cmdW) |=> presetCounters)
		else $error("preset dropped without a command");
	irq_cause_a: assert property (
		$rose(interrupt_request_out) |-> $past(lastRowStart) || $past(lastRowStart, 2))
		else $error("interrupt without last row start");
	irq_clear_a: assert property (
		hostRead && command_param_select && !lastRowStart && !$past(lastRowStart)
		|=> !interrupt_request_out)
		else $error("interrupt kept after status read");
	fixed_bits_a: assert property (
		!readData[7] && !readData[4] && !readData[0])
		else $error("fixed status bits not zero");
	read_select_a: assert property (
		!$past(hostRead && command_param_select) |-> $stable(readData))
		else $error("read data moved without status read");
	underrun_blank_a: assert property (
		underrunEvent && buffer_request |-> ##[1:2] video_suppress)
		else $error("underrun did not blank");
endmodule : crt_cmd_checker

bind crt_command_status crt_cmd_checker u_chk
(
	.sys_clk(sys_clk),
	.rst(rst),
	.hostWrite(hostWrite),
	.hostRead(hostRead),
	.command_param_select(command_param_select),
	.writeData(writeData),
	.readData(readData),
	.lastRowStart(lastRowStart),
	.underrunEvent(underrunEvent),
	.interrupt_request_out(interrupt_request_out),
	.buffer_request(buffer_request),
	.video_suppress(video_suppress),
	.presetCounters(presetCounters)
);

// ==== verif/crt_host_model.sv ====
// host processor model driving the command and parameter bus
module crt_host_model
(
	// clock
	input wire logic sys_clk,
	// host bus
	output logic hostWrite,
	output logic hostRead,
	output logic command_param_select,
	output logic [7:0] writeData,
	input wire logic [7:0] readData
);
	timeunit 1ns;
	timeprecision 1ps;
	initial
	begin
		hostWrite = 1'b0;
		hostRead = 1'b0;
		command_param_select = 1'b1;
		writeData = 8'h00;
	end
	// one cycle strobe; released data shows the inverse so stale bytes never match
	task xfer(input logic rd, input logic sel, input logic [7:0] d, output logic [7:0] q);
		@(posedge sys_clk);
		hostWrite <= !rd;
		hostRead <= rd;
		command_param_select <= sel;
		writeData <= d;
		@(posedge sys_clk);
		hostWrite <= 1'b0;
		hostRead <= 1'b0;
		writeData <= ~d;
		@(posedge sys_clk);
		#1;
		q = readData;
	endtask : xfer
endmodule : crt_host_model

// ==== verif/crt_controller_command_status_bench.sv ====
// self-checking bench for the command and status interpreter
module crt_controller_command_status_bench;
	timeunit 1ns;
	timeprecision 1ps;
	logic sys_clk = 1'b0;
	logic rst = 1'b1;
	logic hostWrite, hostRead, command_param_select, lastRowStart, vretraceEnd, underrunEvent;
	logic [7:0] writeData, readData, cursorChar, cursorRow, q;
	logic interrupt_request_out, buffer_request, video_suppress, presetCounters, spacedRows;
	logic blankEdgeLines, lineCountOffset;
	logic [6:0] charsPerRow;
	logic [1:0] vretraceRows, cursorFormat, kk;
	logic [5:0] rowsPerFrame;
	logic [3:0] underlineLine, linesPerRow, hretraceCount;
	logic [2:0] evt = 3'h0;
	int num_errors = 0;
	int checked = 0;
	assign {underrunEvent, vretraceEnd, lastRowStart} = evt;
	always #2.5 sys_clk = ~sys_clk;
	crt_command_status u_dut
	(
		.sys_clk(sys_clk),
		.rst(rst),
		.hostWrite(hostWrite),
		.hostRead(hostRead),
		.command_param_select(command_param_select),
		.writeData(writeData),
		.readData(readData),
		.lastRowStart(lastRowStart),
		.vretraceEnd(vretraceEnd),
		.underrunEvent(underrunEvent),
		.interrupt_request_out(interrupt_request_out),
		.buffer_request(buffer_request),
		.video_suppress(video_suppress),
		.presetCounters(presetCounters),
		.spacedRows(spacedRows),
		.charsPerRow(charsPerRow),
		.vretraceRows(vretraceRows),
		.rowsPerFrame(rowsPerFrame),
		.underlineLine(underlineLine),
		.linesPerRow(linesPerRow),
		.blankEdgeLines(blankEdgeLines),
		.lineCountOffset(lineCountOffset),
		.cursorFormat(cursorFormat),
		.hretraceCount(hretraceCount),
		.cursorChar(cursorChar),
		.cursorRow(cursorRow)
	);
	crt_host_model u_host
	(
		.sys_clk(sys_clk),
		.hostWrite(hostWrite),
		.hostRead(hostRead),
		.command_param_select(command_param_select),
		.writeData(writeData),
		.readData(readData)
	);
	task chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
		checked++;
		if (seen !== exp)
		begin
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
			num_errors++;
		end
	endtask : chk
	task wr(input logic sel, input logic [7:0] d);
		u_host.xfer(1'b0, sel, d, q);
		@(posedge sys_clk);
		#1;
	endtask : wr
	task st(input logic [7:0] e);
		u_host.xfer(1'b1, 1'b1, 8'h00, q);
		chk("status", q, e);
	endtask : st
	task pulse(input int i);
		@(posedge sys_clk);
		evt[i] <= 1'b1;
		@(posedge sys_clk);
		evt <= 3'h0;
		repeat (2) @(posedge sys_clk);
		#1;
	endtask : pulse
	task print_verdict;
		$display("checked %0d num_errors %0d", checked, num_errors);
		if (num_errors == 0 && checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : print_verdict
	initial
	begin
		repeat (8) @(posedge sys_clk);
		rst <= 1'b0;
		st(8'h00);
		// every cursor style and both blanking choices
		for (int k = 0; k < 4; k++)
		begin
			kk = k[1:0];
			wr(1'b1, 8'h00);
			wr(1'b0, 8'hCF);
			wr(1'b0, 8'hBF);
			wr(1'b0, kk[0] ? 8'h97 : 8'h47);
			wr(1'b0, {kk[0], 1'b0, kk, kk, ~kk});
			chk("spaced", spacedRows, 8'h01);
			chk("chars", charsPerRow, 8'h4F);
			chk("vretrace", vretraceRows, 8'h02);
			chk("rows", rowsPerFrame, 8'h3F);
			chk("underline", underlineLine, kk[0] ? 8'h09 : 8'h04);
			chk("lines", linesPerRow, 8'h07);
			chk("edges", blankEdgeLines, kk[0]);
			chk("offset", lineCountOffset, kk[0]);
			chk("cursorFmt", cursorFormat, kk);
			chk("hretrace", hretraceCount, {kk, ~kk});
			chk("suppress", video_suppress, 8'h01);
			st(8'h00);
		end
		wr(1'b1, 8'h80);
		wr(1'b0, 8'h12);
		wr(1'b0, 8'h34);
		chk("cursorChar", cursorChar, 8'h12);
		chk("cursorRow", cursorRow, 8'h34);
		st(8'h00);
		wr(1'b1, 8'h20);
		chk("bufReq", buffer_request, 8'h01);
		chk("suppress", video_suppress, 8'h00);
		st(8'h44);
		pulse(0);
		chk("irq", interrupt_request_out, 8'h01);
		st(8'h64);
		chk("irq", interrupt_request_out, 8'h00);
		st(8'h44);
		wr(1'b1, 8'hC0);
		pulse(0);
		chk("irq", interrupt_request_out, 8'h00);
		st(8'h04);
		wr(1'b1, 8'hA0);
		st(8'h44);
		wr(1'b1, 8'h40);
		chk("suppress", video_suppress, 8'h01);
		st(8'h40);
		wr(1'b1, 8'h20);
		pulse(2);
		chk("bufReq", buffer_request, 8'h00);
		chk("suppress", video_suppress, 8'h01);
		st(8'h46);
		pulse(1);
		chk("suppress", video_suppress, 8'h00);
		// short string, then a byte nobody asked for
		wr(1'b1, 8'h80);
		wr(1'b0, 8'h55);
		wr(1'b1, 8'hA0);
		st(8'h4C);
		st(8'h44);
		wr(1'b0, 8'h77);
		chk("cursorRow", cursorRow, 8'h34);
		st(8'h4C);
		u_host.xfer(1'b1, 1'b0, 8'h00, q);
		chk("readData", readData, 8'h4C);
		wr(1'b1, 8'hE0);
		repeat (4) @(posedge sys_clk);
		chk("preset", presetCounters, 8'h01);
		wr(1'b1, 8'hC0);
		chk("preset", presetCounters, 8'h00);
		wr(1'b1, 8'h20);
		wr(1'b1, 8'h00);
		chk("bufReq", buffer_request, 8'h00);
		st(8'h00);
		print_verdict();
	end
endmodule : crt_controller_command_status_bench
